// ==== rtl/acc_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by every design file that needs a number.
// Notes:   Definitions only.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// Clock and conversion timing.
`define ACC_CLK_PERIOD_NS  25
`define ACC_PHASE_TIME_NS  33000000
`define ACC_STRAP_WAIT     3'h7

// Two-wire addresses, strap level codes and output framing.
`define ACC_GLOBAL_ADDR    7'h77
`define ACC_STRAP_LOW      2'h0
`define ACC_STRAP_HIGH     2'h1
`define ACC_STRAP_FLOAT    2'h2
`define ACC_ADDR_LL        7'h14
`define ACC_ADDR_LH        7'h16
`define ACC_ADDR_LF        7'h15
`define ACC_ADDR_HL        7'h26
`define ACC_ADDR_HH        7'h34
`define ACC_ADDR_HF        7'h27
`define ACC_ADDR_FL        7'h17
`define ACC_ADDR_FH        7'h25
`define ACC_ADDR_FF        7'h24
`define ACC_OUT_BITS       6'h20
`define ACC_BYTE_BITS      4'h8
`define ACC_LAST_BIT       4'h7

// Configuration byte layout and power-up settings.
`define ACC_CFG_IM_BIT     7
`define ACC_CFG_REJ_HI     6
`define ACC_CFG_REJ_LO     5
`define ACC_CFG_SPD_BIT    4
`define ACC_CHAN_RST       8'h00
`define ACC_CFG_RST        8'h00
`define ACC_REJ_BOTH       2'h0
`define ACC_REJ_50         2'h1
`define ACC_REJ_60         2'h2

// Temperature slope in result counts per kelvin at a 5 V reference.
`define ACC_TEMP_SLOPE     314

`endif

// ==== rtl/acc_pkg.sv ====
// Purpose: Types shared by the conversion control block.
// Assumes: Numbers live in acc_map.svh.
// Notes:   State codes are one-hot.
package acc_pkg;

  typedef enum logic [6:0] {
    ACC_I2C_IDLE = 7'h01,
    ACC_I2C_ADDR = 7'h02,
    ACC_I2C_AACK = 7'h04,
    ACC_I2C_WR   = 7'h08,
    ACC_I2C_WACK = 7'h10,
    ACC_I2C_RD   = 7'h20,
    ACC_I2C_RACK = 7'h40
  } acc_i2c_st_t;

  typedef enum logic [2:0] {
    ACC_CONV_RUN   = 3'h1,
    ACC_CONV_SLEEP = 3'h2,
    ACC_CONV_OUT   = 3'h4
  } acc_conv_st_t;

  // Settings applied to the analogue front end for one conversion.
  typedef struct packed {
    logic [7:0] chan;
    logic       temp_sel;
    logic [1:0] rej;
  } acc_fe_ctrl_t;

  typedef struct packed {
    acc_i2c_st_t  i2c_st;
    acc_conv_st_t conv_st;
    logic         scl_q;
    logic         sda_q;
    logic [7:0]   shreg;
    logic [3:0]   bitcnt;
    logic [5:0]   outcnt;
    logic [31:0]  outword;
    logic         rw;
    logic         glob;
    logic         ack;
    logic         mack;
    logic [1:0]   wr_idx;
    logic         wr_acked;
    logic [7:0]   chan;
    logic [7:0]   cfg;
    logic [6:0]   my_addr;
    logic [2:0]   strap_cnt;
    logic         strap_ok;
    logic         sda_oe;
    logic         sda_o;
    logic         start_conv;
    logic         two_ph;
    logic         result_ready;
    acc_fe_ctrl_t fe;
  } acc_top_st_t;

endpackage

// ==== rtl/acc_sync.sv ====
// Purpose: Three-stage synchroniser for pins from outside the clock domain.
// Assumes: Inputs idle high at reset.
// Notes:   A change counts once stages two and three agree.
`timescale 1ns/1ps
module acc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } acc_sync_st_t;

  acc_sync_st_t r;
  acc_sync_st_t n;

  // Stage one feeds only stage two; the agreement test filters glitches.
  always_comb begin
    n    = r;
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q  = (r.s2 & r.s3) | (r.q & (r.s2 ^ r.s3));
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '1;
    end else begin
      r <= n;
    end
  end

  assign q = r.q;
endmodule // acc_sync

// ==== rtl/acc_conv.sv ====
// Purpose: Conversion timer and offset-cancelling result combiner.
// Assumes: The front end presents a settled code at each phase end.
// Notes:   The front end swaps its input polarity while chop is high.
`timescale 1ns/1ps
module acc_conv #(
  parameter int PHASE_CYCLES = 1320000
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic        two_phase,
  input  wire logic [23:0] code_in,
  output logic             chop,
  output logic             busy,
  output logic             done,
  output logic      [23:0] result
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        busy;
    logic        ph;
    logic        two;
    logic        chop;
    logic        done;
    logic [23:0] a;
    logic [23:0] res;
  } acc_conv_reg_t;

  acc_conv_reg_t r;
  acc_conv_reg_t n;
  logic [24:0]   diff;

  // Each result uses only samples from its own cycle, so no latency.
  always_comb begin
    n      = r;
    n.done = 1'b0;
    diff   = {r.a[23], r.a} - {code_in[23], code_in};
    if (start) begin
      n.busy = 1'b1;
      n.cnt  = 32'h0;
      n.ph   = 1'b0;
      n.chop = 1'b0;
      n.two  = two_phase;
    end else if (r.busy) begin
      n.cnt = r.cnt + 32'h1;
      if (r.cnt == 32'(PHASE_CYCLES - 1)) begin
        n.cnt = 32'h0;
        if (!r.ph && r.two) begin
          n.a    = code_in;
          n.ph   = 1'b1;
          n.chop = 1'b1;
        end else begin
          // Half the chopped difference cancels offset; 2x keeps one.
          n.res  = r.two ? diff[24:1] : code_in;
          n.busy = 1'b0;
          n.chop = 1'b0;
          n.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign chop   = r.chop;
  assign busy   = r.busy;
  assign done   = r.done;
  assign result = r.res;
endmodule // acc_conv

// ==== rtl/acc_top.sv ====
// Purpose: Conversion sequencing and two-wire target of a multi-channel ADC.
// Assumes: Straps arrive as level codes; SDA is open drain.
// Notes:   SDA is only ever pulled low; the enable carries every bit.
// Function
// - Default merges two chopped phases; speed-double gives one phase.
// - Temperature conversions always use the two-phase single-rate mode.
// - Each result settles within its own conversion cycle.
// - Internal-sensor select routes the converter to the temperature sensor.
// - Temperature result passes unscaled, proportional to kelvin.
// - A finished conversion puts the device to sleep, ready to read.
// - An acknowledged read moves sleep into the data output state.
// - STOP or all 32 bits read ends output and starts conversion.
// - Two three-level straps select one of nine addresses.
// - The global address is also answered.
// - Written channel and configuration persist for later conversions.
// - Without any write, power-up defaults are used.
// - A valid address during conversion gets NACK.
// - Write then repeated START read is accepted after completion.
// - The next conversion uses the settings just written.
// - A write may end after the channel byte.
// - Acknowledged write then STOP discards result and restarts.
// - Rejection selects 50 Hz, 60 Hz or both.
// - A global-address read is refused with NACK.
// - A global write then STOP starts every converter together.
`timescale 1ns/1ps
`include "acc_map.svh"
module acc_top #(
  parameter int PHASE_CYCLES = `ACC_PHASE_TIME_NS / `ACC_CLK_PERIOD_NS
) (
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire logic                 scl_pin,
  input  wire logic                 sda_pin_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  input  wire logic [1:0]           addr_strap_low,
  input  wire logic [1:0]           addr_strap_high,
  input  wire logic [23:0]          fe_code,
  output acc_pkg::acc_fe_ctrl_t     fe_ctrl,
  output logic                      fe_chop,
  output logic                      result_ready
);
  import acc_pkg::*;
  acc_top_st_t r;
  acc_top_st_t n;
  logic [5:0]  pins_q;
  logic        scl_f;
  logic        sda_f;
  logic        conv_busy;
  logic        conv_done;
  logic [23:0] conv_res;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic [7:0]  rx_byte;
  logic        go;

  // Strap decode: upper strap picks the row, lower strap the column.
  function automatic logic [6:0] addr_lookup(input logic [1:0] hi,
                                             input logic [1:0] lo);
    logic [6:0] a;
    a = `ACC_ADDR_FF;
    case ({hi, lo})
      {`ACC_STRAP_LOW,   `ACC_STRAP_LOW}:   a = `ACC_ADDR_LL;
      {`ACC_STRAP_LOW,   `ACC_STRAP_HIGH}:  a = `ACC_ADDR_LH;
      {`ACC_STRAP_LOW,   `ACC_STRAP_FLOAT}: a = `ACC_ADDR_LF;
      {`ACC_STRAP_HIGH,  `ACC_STRAP_LOW}:   a = `ACC_ADDR_HL;
      {`ACC_STRAP_HIGH,  `ACC_STRAP_HIGH}:  a = `ACC_ADDR_HH;
      {`ACC_STRAP_HIGH,  `ACC_STRAP_FLOAT}: a = `ACC_ADDR_HF;
      {`ACC_STRAP_FLOAT, `ACC_STRAP_LOW}:   a = `ACC_ADDR_FL;
      {`ACC_STRAP_FLOAT, `ACC_STRAP_HIGH}:  a = `ACC_ADDR_FH;
      default:                              a = `ACC_ADDR_FF;
    endcase
    return a;
  endfunction

  // Bus pins and straps all come from outside the clock domain.
  acc_sync #(.W(6)) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       ({scl_pin, sda_pin_i, addr_strap_high, addr_strap_low}),
    .q       (pins_q)
  );
  assign scl_f = pins_q[5];
  assign sda_f = pins_q[4];

  acc_conv #(.PHASE_CYCLES(PHASE_CYCLES)) u_conv (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .start     (r.start_conv),
    .two_phase (r.two_ph),
    .code_in   (fe_code),
    .chop      (fe_chop),
    .busy      (conv_busy),
    .done      (conv_done),
    .result    (conv_res)
  );

  // Bus conditions seen on the filtered lines.
  assign scl_rise = scl_f & ~r.scl_q;
  assign scl_fall = ~scl_f & r.scl_q;
  assign start_ev = scl_f & r.scl_q & r.sda_q & ~sda_f;
  assign stop_ev  = scl_f & r.scl_q & ~r.sda_q & sda_f;
  assign rx_byte  = {r.shreg[6:0], sda_f};

  // Target state machine, conversion sequencing and settings store.
  always_comb begin
    n            = r;
    go           = 1'b0;
    n.scl_q      = scl_f;
    n.sda_q      = sda_f;
    n.start_conv = 1'b0;
    n.sda_o      = 1'b0;
    // Straps are caught once the synchroniser has settled after reset.
    if (!r.strap_ok) begin
      n.strap_cnt = r.strap_cnt + 3'h1;
      if (r.strap_cnt == `ACC_STRAP_WAIT) begin
        n.my_addr  = addr_lookup(pins_q[3:2], pins_q[1:0]);
        n.strap_ok = 1'b1;
      end
    end
    if (stop_ev) begin
      // A stop ends output, or commits an acknowledged write.
      if (r.conv_st == ACC_CONV_OUT) begin
        go = 1'b1;
      end else if (r.conv_st == ACC_CONV_SLEEP && r.wr_acked) begin
        go = 1'b1;
      end
      n.i2c_st   = ACC_I2C_IDLE;
      n.sda_oe   = 1'b0;
      n.wr_acked = 1'b0;
    end else if (start_ev) begin
      // Repeated start keeps written settings and the pending result.
      n.i2c_st = ACC_I2C_ADDR;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
    end else begin
      case (r.i2c_st)
        ACC_I2C_IDLE: begin
          n.sda_oe = 1'b0;
        end
        ACC_I2C_ADDR: begin
          if (scl_rise) begin
            n.shreg  = rx_byte;
            n.bitcnt = r.bitcnt + 4'h1;
            if (r.bitcnt == `ACC_LAST_BIT) begin
              n.rw   = rx_byte[0];
              n.glob = rx_byte[7:1] == `ACC_GLOBAL_ADDR;
              // Busy converter and global reads are both refused.
              n.ack  = r.strap_ok
                     && (rx_byte[7:1] == r.my_addr || n.glob)
                     && r.conv_st == ACC_CONV_SLEEP
                     && !(n.glob && rx_byte[0]);
            end
          end else if (scl_fall && r.bitcnt == `ACC_BYTE_BITS) begin
            n.sda_oe = r.ack;
            n.i2c_st = r.ack ? ACC_I2C_AACK : ACC_I2C_IDLE;
          end
        end
        ACC_I2C_AACK: begin
          if (scl_fall) begin
            n.bitcnt = 4'h0;
            if (r.rw) begin
              n.conv_st = ACC_CONV_OUT;
              n.outcnt  = 6'h0;
              n.sda_oe  = ~r.outword[31];
              n.outword = {r.outword[30:0], 1'b0};
              n.i2c_st  = ACC_I2C_RD;
            end else begin
              n.sda_oe   = 1'b0;
              n.wr_acked = 1'b1;
              n.wr_idx   = 2'h0;
              n.i2c_st   = ACC_I2C_WR;
            end
          end
        end
        ACC_I2C_WR: begin
          if (scl_rise) begin
            n.shreg  = rx_byte;
            n.bitcnt = r.bitcnt + 4'h1;
            if (r.bitcnt == `ACC_LAST_BIT) begin
              // Settings stay until overwritten by a later write.
              if (r.wr_idx == 2'h0) begin
                n.chan = rx_byte;
              end else if (r.wr_idx == 2'h1) begin
                n.cfg = rx_byte;
              end
              if (r.wr_idx != 2'h2) begin
                n.wr_idx = r.wr_idx + 2'h1;
              end
            end
          end else if (scl_fall && r.bitcnt == `ACC_BYTE_BITS) begin
            n.sda_oe = 1'b1;
            n.i2c_st = ACC_I2C_WACK;
          end
        end
        ACC_I2C_WACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.bitcnt = 4'h0;
            n.i2c_st = ACC_I2C_WR;
          end
        end
        ACC_I2C_RD: begin
          if (scl_rise) begin
            n.bitcnt = r.bitcnt + 4'h1;
            n.outcnt = r.outcnt + 6'h1;
          end else if (scl_fall) begin
            if (r.bitcnt == `ACC_BYTE_BITS) begin
              n.sda_oe = 1'b0;
              if (r.outcnt == `ACC_OUT_BITS) begin
                go       = 1'b1;
                n.i2c_st = ACC_I2C_IDLE;
              end else begin
                n.i2c_st = ACC_I2C_RACK;
              end
            end else begin
              n.sda_oe  = ~r.outword[31];
              n.outword = {r.outword[30:0], 1'b0};
            end
          end
        end
        ACC_I2C_RACK: begin
          if (scl_rise) begin
            n.mack = ~sda_f;
          end else if (scl_fall) begin
            n.bitcnt = 4'h0;
            if (r.mack) begin
              n.sda_oe  = ~r.outword[31];
              n.outword = {r.outword[30:0], 1'b0};
              n.i2c_st  = ACC_I2C_RD;
            end else begin
              n.sda_oe = 1'b0;
              n.i2c_st = ACC_I2C_IDLE;
            end
          end
        end
        default: begin
          n.i2c_st = ACC_I2C_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
    // Completion puts the converter to sleep with the word ready.
    if (conv_done) begin
      n.conv_st      = ACC_CONV_SLEEP;
      n.result_ready = 1'b1;
      // No scaling, so a temperature code stays proportional to kelvin.
      n.outword      = {~conv_res[23], conv_res[23], conv_res, 6'h00};
    end
    // A new conversion latches the newest settings into the front end.
    if (go) begin
      n.start_conv   = 1'b1;
      n.conv_st      = ACC_CONV_RUN;
      n.result_ready = 1'b0;
      n.wr_acked     = 1'b0;
      n.fe.chan      = n.chan;
      n.fe.temp_sel  = n.cfg[`ACC_CFG_IM_BIT];
      n.fe.rej       = n.cfg[`ACC_CFG_REJ_HI:`ACC_CFG_REJ_LO];
      n.two_ph       = ~n.cfg[`ACC_CFG_SPD_BIT]
                     | n.cfg[`ACC_CFG_IM_BIT];
    end
  end

  // Reset starts the first conversion on default settings.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r              <= '0;
      r.i2c_st       <= ACC_I2C_IDLE;
      r.conv_st      <= ACC_CONV_RUN;
      r.scl_q        <= 1'b1;
      r.sda_q        <= 1'b1;
      r.chan         <= `ACC_CHAN_RST;
      r.cfg          <= `ACC_CFG_RST;
      r.fe.chan      <= `ACC_CHAN_RST;
      r.fe.rej       <= `ACC_REJ_BOTH;
      r.start_conv   <= 1'b1;
      r.two_ph       <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign sda_o        = r.sda_o;
  assign sda_oe       = r.sda_oe;
  assign fe_ctrl      = r.fe;
  assign result_ready = r.result_ready;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_addr_done;
    r.i2c_st == ACC_I2C_ADDR && scl_fall && r.bitcnt == `ACC_BYTE_BITS;
  endsequence
  sequence s_read_acked;
    r.i2c_st == ACC_I2C_AACK && scl_fall && r.rw;
  endsequence
  sequence s_restart;
    r.start_conv ##1 conv_busy;
  endsequence

  a_busy_nack: assert property (s_addr_done and r.conv_st == ACC_CONV_RUN
    |=> r.i2c_st == ACC_I2C_IDLE && !r.sda_oe) else $error("busy ack");
  a_global_read_nack: assert property (s_addr_done and (r.glob && r.rw)
    |=> !r.sda_oe) else $error("global read acknowledged");
  a_sleep_on_done: assert property (conv_done
    |=> r.conv_st == ACC_CONV_SLEEP && r.result_ready) else $error("no sleep");
  a_read_to_out: assert property (s_read_acked
    |=> r.conv_st == ACC_CONV_OUT) else $error("no output state");
  a_msb_first: assert property (s_read_acked
    |=> r.sda_oe == !$past(r.outword[31])) else $error("first bit wrong");
  a_stop_restart: assert property (stop_ev && r.conv_st == ACC_CONV_OUT
    |=> s_restart) else $error("stop did not restart");
  a_write_restart: assert property (stop_ev && r.wr_acked
    && r.conv_st == ACC_CONV_SLEEP |=> s_restart) else $error("no restart");
  a_temp_one_x: assert property (r.start_conv && r.fe.temp_sel
    |-> r.two_ph) else $error("temperature in 2x mode");
  a_settings_apply: assert property (r.start_conv
    |-> r.fe.chan == r.chan
        && r.fe.temp_sel == r.cfg[`ACC_CFG_IM_BIT]) else $error("stale set");
  a_strap_addr: assert property ($rose(r.strap_ok)
    |-> r.my_addr == addr_lookup($past(pins_q[3:2]), $past(pins_q[1:0])))
    else $error("strap address wrong");
endmodule // acc_top

// ==== bench/acc_i2c_mst.sv ====
// Purpose: Two-wire bus master model facing the converter's target port.
// Assumes: The bench resolves SDA as an open-drain line with a pull-up.
// Notes:   SCL idles high and toggles only inside frames.
`timescale 1ns/1ps
module acc_i2c_mst (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // A quarter of the 200 ns bus clock period.
  localparam time Q = 50;

  // The bus idles released with SCL high.
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // One clock: set SDA early in the low phase, sample halfway through the high one.
  // The low phase is stretched to 150 ns because the target answers about
  // five of its clocks after the SCL fall; SDA must settle before SCL rises.
  task automatic bit_cyc(input logic b, output logic s);
    #Q sda_low = !b;
    #(2*Q) scl = 1'b1;
    #(Q/2) s = sda;
    #(Q/2) scl = 1'b0;
  endtask

  // START or repeated START; waits so the target has dropped its ACK.
  task automatic start();
    #(2*Q) sda_low = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask

  // STOP; right after an eighth bit it falls in the acknowledge slot.
  task automatic stop();
    #(2*Q) sda_low = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask

  // Eight bits MSB first, then the acknowledge clock.
  task automatic xfer(input logic [7:0] wb, input logic rd,
                      input logic mack, output logic [7:0] rb,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(rd | wb[i], s);
      rb[i] = s;
    end
    bit_cyc(rd ? !mack : 1'b1, s);
    ack = !s;
  endtask
endmodule // acc_i2c_mst

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the conversion control block.
// Assumes: A front-end model answers fe_ctrl and fe_chop at once.
// Notes:   PHASE_CYCLES is cut to 100, so 1x takes 200 cycles.
`timescale 1ns/1ps
module tb;
  import acc_pkg::*;

  localparam int          PH   = 100;
  localparam logic [6:0]  ADR  = 7'h24;
  localparam logic [6:0]  GADR = 7'h77;
  localparam logic [23:0] OFS  = 24'h000400;
  localparam logic [23:0] TEMP = 24'h016FF8; // 300 K at 314 per kelvin.

  logic         ref_clk, nrst, scl, sda_low, sda, sda_o, sda_oe;
  logic         fe_chop, result_ready;
  logic [1:0]   st_lo, st_hi;
  logic [23:0]  v, fe_code;
  acc_fe_ctrl_t fe_ctrl;
  int           failures, checks;
  // Rows of channel byte and configuration byte.
  logic [15:0]  rows [4] = '{16'h0320, 16'h0550, 16'h0590, 16'h0000};
  // Strap addresses, upper strap major; codes low, high, float.
  logic [6:0]   adr9 [9] = '{7'h14, 7'h16, 7'h15, 7'h26, 7'h34, 7'h27,
                             7'h17, 7'h25, 7'h24};

  // 40 MHz clock.
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  // Open-drain SDA with a pull-up; the front end adds an offset and
  // negates the signal while chopped, so only 1x cancels the offset.
  assign sda     = !(sda_low || (sda_oe && !sda_o));
  assign v       = fe_ctrl.temp_sel ? TEMP : {8'h01, fe_ctrl.chan, 8'h00};
  assign fe_code = fe_chop ? OFS - v : OFS + v;

  acc_top #(.PHASE_CYCLES(PH)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .scl_pin(scl), .sda_pin_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_low(st_lo),
    .addr_strap_high(st_hi), .fe_code(fe_code), .fe_ctrl(fe_ctrl),
    .fe_chop(fe_chop), .result_ready(result_ready)
  );

  acc_i2c_mst i_mst (.scl(scl), .sda_low(sda_low), .sda(sda));

  task automatic complete_run();
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Lets n edges pass, then steps clear of the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  // Bounded wait for a held result.
  task automatic wait_rdy();
    int n;
    n = 0;
    while (result_ready !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    chk("ready", 1, result_ready);
  endtask

  // Five cycles of reset with new straps, idle outputs checked meanwhile.
  task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
    tick(1);
    nrst  = 1'b0;
    st_hi = hi;
    st_lo = lo;
    tick(5);
    chk("rst", 0, {sda_oe, result_ready, fe_chop, fe_ctrl});
    nrst = 1'b1;
  endtask

  task automatic frame(input logic [6:0] ad, input logic rd,
                       output logic ack);
    logic [7:0] d;
    i_mst.start();
    i_mst.xfer({ad, rd}, 1'b0, 1'b0, d, ack);
  endtask

  // Four bytes, all acknowledged but the last; output ends after bit 32.
  task automatic rd_word(output logic [31:0] w);
    logic [7:0] d;
    logic       a;
    for (int i = 3; i >= 0; i--) begin
      i_mst.xfer(8'hFF, 1'b1, i != 0, d, a);
      w = {w[23:0], d};
    end
    tick(2);
    chk("out_end", 0, result_ready);
    i_mst.stop();
  endtask

  // STOP, then see whether a conversion was started.
  task automatic end_chk(input logic rr);
    i_mst.stop();
    tick(4);
    chk("ready", rr, result_ready);
  endtask

  // Expected word; the sensor always runs 1x, so keeps no offset.
  function automatic logic [31:0] word(input logic [7:0] ch,
                                       input logic [7:0] cf);
    logic [23:0] r;
    r = cf[7] ? TEMP : {8'h01, ch, 8'h00};
    if (cf[4] && !cf[7])
      r = r + OFS;
    return {~r[23], r[23], r, 6'h00};
  endfunction

  initial begin
    logic        a, s;
    logic [7:0]  d, ch, cf;
    logic [31:0] w;
    failures = 0;
    checks   = 0;
    nrst     = 1'b0;
    st_lo    = 2'h2;
    st_hi    = 2'h2;
    do_reset(2'h2, 2'h2);
    ch = 8'h00;
    cf = 8'h00;
    // Write, repeated START, read the result made with the last settings.
    foreach (rows[i]) begin
      wait_rdy();
      frame(ADR, 1'b0, a);
      i_mst.xfer(rows[i][15:8], 1'b0, 1'b0, d, a);
      i_mst.xfer(rows[i][7:0], 1'b0, 1'b0, d, a);
      chk("wr_ack", 1, a);
      frame(ADR, 1'b1, a);
      chk("rd_ack", 1, a);
      rd_word(w);
      chk("word", word(ch, cf), w);
      ch = rows[i][15:8];
      cf = rows[i][7:0];
      tick(4);
      chk("fe_ctrl", {ch, cf[7], cf[6:5]}, fe_ctrl);
    end
    // Probed at once, the fresh conversion is still running.
    frame(ADR, 1'b1, a);
    chk("busy", 0, a);
    i_mst.stop();
    wait_rdy();
    frame(GADR, 1'b1, a);
    chk("gread", 0, a);
    end_chk(1'b1);
    // Global write of a channel byte alone, then STOP.
    frame(GADR, 1'b0, a);
    chk("gwrite", 1, a);
    i_mst.xfer(8'h07, 1'b0, 1'b0, d, a);
    end_chk(1'b0);
    ch = 8'h07;
    chk("chan", ch, fe_ctrl.chan);
    wait_rdy();
    frame(ADR, 1'b1, a);
    rd_word(w);
    chk("word", word(ch, cf), w);
    // One byte, then STOP in the acknowledge slot.
    wait_rdy();
    frame(ADR, 1'b1, a);
    for (int i = 0; i < 8; i++) begin
      i_mst.bit_cyc(1'b1, s);
      d = {d[6:0], s};
    end
    end_chk(1'b0);
    w = word(ch, cf);
    chk("byte", w[31:24], d);
    // Each strap pair answers its own address but not the one with its low bit flipped.
    for (int i = 0; i < 9; i++) begin
      do_reset(2'(i / 3), 2'(i % 3));
      wait_rdy();
      frame(adr9[i] ^ 7'h01, 1'b0, a);
      chk("other", 0, a);
      i_mst.stop();
      frame(adr9[i], 1'b0, a);
      chk("addr", 1, a);
      end_chk(1'b0);
    end
    complete_run();
  end

  // Watchdog: the traffic needs well under 400 us.
  initial begin
    #1000000;
    failures++;
    complete_run();
  end
endmodule // tb
